// >>> hdl/spm_pin_mux.sv
// Pin sharing between port registers and on-chip peripherals.
// Assumes pins are resolved outside from out, oe_n and the pull controls.
//
// Behaviour
// - Out of reset all 39 shared pins except D0, which the debug function drives when it asks, are undriven inputs, pulls off except the D1 and D0 pullups.
// - Direction bit picks latch or pin for data reads, even peripheral-owned.
// - Owning peripheral, not direction bit, enables the output buffer.
// - Pull enable controls the pull whenever the pin is an input, except D1 and D0 while their functions force a pullup.
// - Port A 7..4 under keypad with rising sensitivity use pulldown.
// - Port D 2 as rising external interrupt uses pulldown.
// - Port A feeds keypad one 7..0; port C 3..0 feeds keypad two.
// - Timer channel one on port B 7, channel zero on port D 6.
// - Port B 1 is async receive, port B 0 async transmit.
// - Port C 7..4 carry slave select, clock, MISO, MOSI.
// - Port D 5 comparator plus, port D 4 comparator minus.
// - Port D 2 interrupt, D 1 reset, D 0 debug mode select.
// - Port D 0 as port pin is output only.
// - Port D 1 as port pin is output only.
// - Port A 0 is input only, still a keypad input.
// - Port B 6..2 and port E only driven by port logic.
// - Reset function active while its option bit set; set by reset.
// - Debug function until its option bit cleared; pullup while active.
`timescale 1ns/10ps
module spm_pin_mux
    import spm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [4:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] port_a_pins_in,
    output logic      [7:0] port_a_pins_out,
    output logic      [7:0] port_a_pins_oe_n,
    output logic      [7:0] port_a_pins_pull_up,
    output logic      [7:0] port_a_pins_pull_dn,
    input  wire logic [7:0] port_b_pins_in,
    output logic      [7:0] port_b_pins_out,
    output logic      [7:0] port_b_pins_oe_n,
    output logic      [7:0] port_b_pins_pull_up,
    output logic      [7:0] port_b_pins_pull_dn,
    input  wire logic [7:0] port_c_pins_in,
    output logic      [7:0] port_c_pins_out,
    output logic      [7:0] port_c_pins_oe_n,
    output logic      [7:0] port_c_pins_pull_up,
    output logic      [7:0] port_c_pins_pull_dn,
    input  wire logic [6:0] port_d_pins_in,
    output logic      [6:0] port_d_pins_out,
    output logic      [6:0] port_d_pins_oe_n,
    output logic      [6:0] port_d_pins_pull_up,
    output logic      [6:0] port_d_pins_pull_dn,
    input  wire logic [7:0] port_e_pins_in,
    output logic      [7:0] port_e_pins_out,
    output logic      [7:0] port_e_pins_oe_n,
    output logic      [7:0] port_e_pins_pull_up,
    output logic      [7:0] port_e_pins_pull_dn,
    input  wire logic [7:0] keypad_one_enable,
    input  wire logic [3:0] keypad_one_rising,
    output logic      [7:0] keypad_one_inputs,
    input  wire logic [3:0] keypad_two_enable,
    output logic      [3:0] keypad_two_inputs,
    input  wire logic       timer_channel_one_en,
    input  wire logic       timer_channel_one_oe,
    input  wire logic       timer_channel_one_out,
    output logic            timer_channel_one_in,
    input  wire logic       timer_channel_zero_en,
    input  wire logic       timer_channel_zero_oe,
    input  wire logic       timer_channel_zero_out,
    output logic            timer_channel_zero_in,
    input  wire logic       async_receive_en,
    output logic            async_receive_in,
    input  wire logic       async_transmit_en,
    input  wire logic       async_transmit_out,
    input  wire logic       spi_enable,
    input  wire logic [3:0] spi_pins_oe,
    input  wire logic [3:0] spi_pins_out,
    output logic            spi_slave_select,
    output logic            spi_serial_clock,
    output logic            spi_master_in_line,
    output logic            spi_master_out_line,
    input  wire logic       comparator_enable,
    output logic            comparator_plus_input,
    output logic            comparator_minus_input,
    input  wire logic       ext_irq_enable,
    input  wire logic       ext_irq_rising,
    output logic            ext_irq_input,
    output logic            reset_pin_request,
    input  wire logic       debug_mode_select_oe,
    input  wire logic       debug_mode_select_out,
    output logic            debug_mode_select_pin,
    output logic            reset_pin_enable,
    output logic            debug_pin_enable
);
    // ------------------------------------------------------------
    // Pin synchronisers and flat pin view
    // ------------------------------------------------------------
    logic [39:0]                 pin_raw;
    logic [39:0]                 sync1_q;
    logic [39:0]                 sync2_q;
    logic [SPM_PORTS-1:0][7:0]   data_q;
    logic [SPM_PORTS-1:0][7:0]   dir_q;
    logic [SPM_PORTS-1:0][7:0]   pull_q;
    logic [1:0]                  option_q;
    logic [39:0]                 own;
    logic [39:0]                 p_drv;
    logic [39:0]                 p_val;
    logic [39:0]                 pd_sel;
    logic [39:0]                 force_pu;
    logic [39:0]                 out_only;
    logic [39:0]                 in_only;
    logic [39:0]                 drv;
    logic [39:0]                 val;
    logic [39:0]                 pu;
    logic [39:0]                 pd;
    logic [2:0]                  sel_port;
    logic [4:0]                  sel_field;
    logic [7:0]                  sel_mask;
    logic [7:0]                  rdata_d;

    assign pin_raw = {port_e_pins_in, 1'b0, port_d_pins_in, port_c_pins_in,
                      port_b_pins_in, port_a_pins_in};

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= 40'h0;
            sync2_q <= 40'h0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    assign sel_port  = reg_addr[4:SPM_PORT_SHIFT];
    assign sel_field = {3'h0, reg_addr[1:0]};
    assign sel_mask  = (sel_port == SPM_PORT_D) ? SPM_D_MASK : SPM_FULL_MASK;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            data_q <= {SPM_PORTS{SPM_PORT_RST}};
            dir_q  <= {SPM_PORTS{SPM_PORT_RST}};
            pull_q <= {SPM_PORTS{SPM_PORT_RST}};
        end else if (reg_wr && sel_port < 3'(SPM_PORTS)) begin
            if (sel_field == SPM_DATA_OFS) begin
                data_q[sel_port] <= reg_wdata & sel_mask;
            end
            if (sel_field == SPM_DIR_OFS) begin
                dir_q[sel_port] <= reg_wdata & sel_mask;
            end
            if (sel_field == SPM_PULL_OFS) begin
                pull_q[sel_port] <= reg_wdata & sel_mask;
            end
        end
    end

    // Both pin functions start enabled after every reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            option_q <= SPM_OPTION_RST;
        end else if (reg_wr && reg_addr == SPM_OPTION_OFS) begin
            option_q <= reg_wdata[1:0];
        end
    end

    always_comb begin
        rdata_d = 8'h00;
        if (reg_addr == SPM_OPTION_OFS) begin
            rdata_d = {6'h0, option_q};
        end else if (sel_port < 3'(SPM_PORTS)) begin
            unique case (sel_field)
                SPM_DATA_OFS: rdata_d = sel_mask & ((dir_q[sel_port] & data_q[sel_port])
                                 | (~dir_q[sel_port] & sync2_q[sel_port*8 +: 8]));
                SPM_DIR_OFS:  rdata_d = dir_q[sel_port];
                SPM_PULL_OFS: rdata_d = pull_q[sel_port];
                default:      rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rdata_d : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Ownership map
    // ------------------------------------------------------------
    always_comb begin
        own      = 40'h0;
        p_drv    = 40'h0;
        p_val    = 40'h0;
        pd_sel   = 40'h0;
        force_pu = 40'h0;
        out_only = 40'h0;
        in_only  = 40'h0;
        own[7:0]    = keypad_one_enable;
        pd_sel[7:4] = keypad_one_enable[7:4] & keypad_one_rising;
        in_only[0]  = 1'b1;
        own[8]   = async_transmit_en;
        p_drv[8] = async_transmit_en;
        p_val[8] = async_transmit_out;
        own[9]   = async_receive_en;
        own[15]  = timer_channel_one_en;
        p_drv[15] = timer_channel_one_oe;
        p_val[15] = timer_channel_one_out;
        own[19:16]   = keypad_two_enable;
        own[23:20]   = {4{spi_enable}};
        p_drv[23:20] = {4{spi_enable}} & spi_pins_oe;
        p_val[23:20] = spi_pins_out;
        own[24]      = option_q[SPM_DBG_EN_BIT];
        p_drv[24]    = option_q[SPM_DBG_EN_BIT] & debug_mode_select_oe;
        p_val[24]    = debug_mode_select_out;
        force_pu[24] = option_q[SPM_DBG_EN_BIT];
        out_only[24] = ~option_q[SPM_DBG_EN_BIT];
        own[25]      = option_q[SPM_RST_EN_BIT];
        force_pu[25] = option_q[SPM_RST_EN_BIT];
        out_only[25] = ~option_q[SPM_RST_EN_BIT];
        own[26]    = ext_irq_enable;
        pd_sel[26] = ext_irq_enable & ext_irq_rising;
        own[29:28] = {2{comparator_enable}};
        own[30]    = timer_channel_zero_en;
        p_drv[30]  = timer_channel_zero_oe;
        p_val[30]  = timer_channel_zero_out;
        in_only[31] = 1'b1;
    end

    // ------------------------------------------------------------
    // Per-pin buffer and pull control
    // ------------------------------------------------------------
    for (genvar i = 0; i < 40; i++) begin : g_pin
        localparam int P = i / 8;
        localparam int B = i % 8;
        always_comb begin
            if (in_only[i]) begin
                drv[i] = 1'b0;
            end else if (own[i]) begin
                drv[i] = p_drv[i];
            end else begin
                drv[i] = dir_q[P][B] | out_only[i];
            end
            val[i] = own[i] ? p_val[i] : data_q[P][B];
            pu[i]  = ~drv[i] & (force_pu[i] | (pull_q[P][B] & ~pd_sel[i]));
            pd[i]  = ~drv[i] & ~force_pu[i] & pull_q[P][B] & pd_sel[i];
        end
    end

    assign port_a_pins_out     = val[7:0];
    assign port_a_pins_oe_n    = ~drv[7:0];
    assign port_a_pins_pull_up = pu[7:0];
    assign port_a_pins_pull_dn = pd[7:0];
    assign port_b_pins_out     = val[15:8];
    assign port_b_pins_oe_n    = ~drv[15:8];
    assign port_b_pins_pull_up = pu[15:8];
    assign port_b_pins_pull_dn = pd[15:8];
    assign port_c_pins_out     = val[23:16];
    assign port_c_pins_oe_n    = ~drv[23:16];
    assign port_c_pins_pull_up = pu[23:16];
    assign port_c_pins_pull_dn = pd[23:16];
    assign port_d_pins_out     = val[30:24];
    assign port_d_pins_oe_n    = ~drv[30:24];
    assign port_d_pins_pull_up = pu[30:24];
    assign port_d_pins_pull_dn = pd[30:24];
    assign port_e_pins_out     = val[39:32];
    assign port_e_pins_oe_n    = ~drv[39:32];
    assign port_e_pins_pull_up = pu[39:32];
    assign port_e_pins_pull_dn = pd[39:32];

    // ------------------------------------------------------------
    // Peripheral inputs
    // ------------------------------------------------------------
    assign keypad_one_inputs      = sync2_q[7:0];
    assign keypad_two_inputs      = sync2_q[19:16];
    assign async_receive_in       = sync2_q[9];
    assign timer_channel_one_in   = sync2_q[15];
    assign spi_master_out_line    = sync2_q[20];
    assign spi_master_in_line     = sync2_q[21];
    assign spi_serial_clock       = sync2_q[22];
    assign spi_slave_select       = sync2_q[23];
    assign debug_mode_select_pin  = sync2_q[24];
    assign reset_pin_request      = option_q[SPM_RST_EN_BIT] & ~sync2_q[25];
    assign ext_irq_input          = sync2_q[26];
    assign comparator_minus_input = sync2_q[28];
    assign comparator_plus_input  = sync2_q[29];
    assign timer_channel_zero_in  = sync2_q[30];
    assign reset_pin_enable       = option_q[SPM_RST_EN_BIT];
    assign debug_pin_enable       = option_q[SPM_DBG_EN_BIT];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic started_q;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    reset_hiz_a: assert property (!started_q && !reg_wr |-> ##1
        (|{drv[39:32], drv[30:26], drv[23:0]} == 1'b0)
        && (|{pu[39:32], pu[30:26], pu[23:0]} == 1'b0))
        else $error("pins not undriven inputs after reset");
    read_source_a: assert property (reg_rd && reg_addr == SPM_DATA_OFS |=>
        reg_rdata == $past((dir_q[0] & data_q[0]) | (~dir_q[0] & sync2_q[7:0])))
        else $error("port data read from wrong source");
    periph_oe_a: assert property (timer_channel_one_en |->
        port_b_pins_oe_n[7] == !timer_channel_one_oe)
        else $error("owned pin buffer not from peripheral");
    pull_ctl_a: assert property (keypad_two_enable[0] |->
        port_c_pins_pull_up[0] == pull_q[2][0])
        else $error("pull not following pull enable");
    kbi_pulldown_a: assert property (keypad_one_enable[5] && keypad_one_rising[1]
        && port_a_pins_oe_n[5] |-> port_a_pins_pull_dn[5] == pull_q[0][5]
        && !port_a_pins_pull_up[5])
        else $error("keypad pulldown wrong");
    irq_pulldown_a: assert property (ext_irq_enable && ext_irq_rising |->
        port_d_pins_pull_dn[2] == pull_q[3][2] && !port_d_pins_pull_up[2])
        else $error("interrupt pulldown wrong");
    out_only_a: assert property (!option_q[SPM_DBG_EN_BIT] |->
        !port_d_pins_oe_n[0] && port_d_pins_out[0] == data_q[3][0])
        else $error("mode pin not output only");
    reset_pin_a: assert property (reg_wr && reg_addr == SPM_OPTION_OFS
        && reg_wdata[0] |=> port_d_pins_oe_n[1] && port_d_pins_pull_up[1])
        else $error("reset pin function not active");
    input_only_a: assert property (port_a_pins_oe_n[0])
        else $error("input only pin driven");
    port_only_a: assert property (port_e_pins_oe_n == ~dir_q[4]
        && port_e_pins_out == data_q[4])
        else $error("plain port pin not from port logic");

    spi_own_c: cover property (spi_enable && !port_c_pins_oe_n[6]);
    dbg_release_c: cover property (option_q[1] ##1 !option_q[1]);
    kbi_rise_c: cover property (keypad_one_enable[4] && keypad_one_rising[0]
        && port_a_pins_pull_dn[4]);
endmodule

// >>> hdl/spm_pkg.sv
// Constants for the shared pin function multiplexer.
// Assumes one bus clock and a plain byte-wide register port.
package spm_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] SPM_DATA_OFS   = 5'h00;
    localparam logic [4:0] SPM_DIR_OFS    = 5'h01;
    localparam logic [4:0] SPM_PULL_OFS   = 5'h02;
    localparam int         SPM_PORT_SHIFT = 2;
    localparam logic [4:0] SPM_OPTION_OFS = 5'h14;
    localparam int         SPM_RST_EN_BIT = 0;
    localparam int         SPM_DBG_EN_BIT = 1;
    // ------------------------------------------------------------
    // Reset values and port shape
    // ------------------------------------------------------------
    localparam logic [7:0] SPM_PORT_RST   = 8'h00;
    localparam logic [1:0] SPM_OPTION_RST = 2'h3;
    localparam int         SPM_PORTS      = 5;
    localparam logic [2:0] SPM_PORT_D     = 3'h3;
    localparam logic [7:0] SPM_D_MASK     = 8'h7f;
    localparam logic [7:0] SPM_FULL_MASK  = 8'hff;
endpackage

// >>> dv/spm_pin_model.sv
// Pad model for one eight-pin port: resolves each pad from the mux drive,
// the pulls and an outside driver. Assumes the bench never fights the mux.
`timescale 1ns/10ps
module spm_pin_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe_n,
    input  wire logic [7:0] pull_up,
    input  wire logic [7:0] pull_dn,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pad
);
    logic [7:0] last_q = 8'h00;

    // Floating pads toggle each cycle so a stale level never looks valid
    always_ff @(posedge ref_clk) begin
        last_q <= pad;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!oe_n[i]) begin
                pad[i] = out[i];
            end else if (ext_en[i]) begin
                pad[i] = ext_val[i];
            end else if (pull_up[i]) begin
                pad[i] = 1'b1;
            end else if (pull_dn[i]) begin
                pad[i] = 1'b0;
            end else begin
                pad[i] = ~last_q[i];
            end
        end
    end
endmodule

// >>> dv/shared_pin_function_mux_bench.sv
// Bench for the shared pin multiplexer: a table of port set-ups, then
// hand tests. Assumes spm_pkg, spm_pin_mux and spm_pin_model are compiled.
`timescale 1ns/10ps
module shared_pin_function_mux_bench;
    import spm_pkg::*;
    typedef struct packed {
        logic [2:0] p;
        logic [7:0] dir, dat, pul, oe, out, pu;
    } spm_row_t;

    logic            ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0]      reg_addr = 5'h00;
    logic [7:0]      reg_wdata = 8'h00, reg_rdata, rd_v;
    logic [7:0]      port_a_pins_in, port_a_pins_out, port_a_pins_oe_n;
    logic [7:0]      port_a_pins_pull_up, port_a_pins_pull_dn;
    logic [7:0]      port_b_pins_in, port_b_pins_out, port_b_pins_oe_n;
    logic [7:0]      port_b_pins_pull_up, port_b_pins_pull_dn;
    logic [7:0]      port_c_pins_in, port_c_pins_out, port_c_pins_oe_n;
    logic [7:0]      port_c_pins_pull_up, port_c_pins_pull_dn;
    logic [6:0]      port_d_pins_in, port_d_pins_out, port_d_pins_oe_n;
    logic [6:0]      port_d_pins_pull_up, port_d_pins_pull_dn;
    logic [7:0]      port_e_pins_in, port_e_pins_out, port_e_pins_oe_n;
    logic [7:0]      port_e_pins_pull_up, port_e_pins_pull_dn;
    logic [7:0]      keypad_one_enable, keypad_one_inputs;
    logic [3:0]      keypad_one_rising, keypad_two_enable, keypad_two_inputs;
    logic [3:0]      spi_pins_oe, spi_pins_out;
    logic            timer_channel_one_en, timer_channel_one_oe, timer_channel_one_out;
    logic            timer_channel_zero_en, timer_channel_zero_oe, timer_channel_zero_out;
    logic            async_receive_en, async_transmit_en, async_transmit_out, spi_enable;
    logic            comparator_enable, ext_irq_enable, ext_irq_rising;
    logic            debug_mode_select_oe, debug_mode_select_out;
    logic            timer_channel_one_in, timer_channel_zero_in, async_receive_in;
    logic            spi_slave_select, spi_serial_clock, spi_master_in_line;
    logic            spi_master_out_line, comparator_plus_input, comparator_minus_input;
    logic            ext_irq_input, reset_pin_request, debug_mode_select_pin;
    logic            reset_pin_enable, debug_pin_enable;
    logic [4:0][7:0] oe_all, out_all, pu_all, pd_all, pad_all, ext_en, ext_val;
    int              num_errors = 0;
    int              check_count = 0;
    spm_row_t        rows [6] = '{
        '{3'h4, 8'hff, 8'h5a, 8'h00, 8'h00, 8'h5a, 8'h00},
        '{3'h4, 8'h0f, 8'h3c, 8'hf0, 8'hf0, 8'h0c, 8'hf0},
        '{3'h1, 8'hff, 8'h81, 8'h00, 8'h00, 8'h81, 8'h00},
        '{3'h0, 8'hff, 8'hff, 8'h00, 8'h01, 8'hfe, 8'h00},
        '{3'h2, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff},
        '{3'h3, 8'h7f, 8'h55, 8'h00, 8'h03, 8'h54, 8'h03}};

    always #5 ref_clk = ~ref_clk;

    spm_pin_mux u_spm_pin_mux (.*);

    assign oe_all  = {port_e_pins_oe_n, 1'b0, port_d_pins_oe_n, port_c_pins_oe_n,
                      port_b_pins_oe_n, port_a_pins_oe_n};
    assign out_all = {port_e_pins_out, 1'b0, port_d_pins_out, port_c_pins_out,
                      port_b_pins_out, port_a_pins_out};
    assign pu_all  = {port_e_pins_pull_up, 1'b0, port_d_pins_pull_up, port_c_pins_pull_up,
                      port_b_pins_pull_up, port_a_pins_pull_up};
    assign pd_all  = {port_e_pins_pull_dn, 1'b0, port_d_pins_pull_dn, port_c_pins_pull_dn,
                      port_b_pins_pull_dn, port_a_pins_pull_dn};
    assign {port_e_pins_in, port_d_pins_in, port_c_pins_in, port_b_pins_in, port_a_pins_in} =
           {pad_all[4], pad_all[3][6:0], pad_all[2], pad_all[1], pad_all[0]};

    for (genvar g = 0; g < 5; g++) begin : g_pad
        spm_pin_model u_spm_pin_model (.ref_clk(ref_clk), .out(out_all[g]), .oe_n(oe_all[g]),
            .pull_up(pu_all[g]), .pull_dn(pd_all[g]), .ext_en(ext_en[g]),
            .ext_val(ext_val[g]), .pad(pad_all[g]));
    end

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [4:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
        @(posedge ref_clk);
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic sync();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic periph_off();
        {timer_channel_one_en, timer_channel_one_oe, timer_channel_one_out,
         timer_channel_zero_en, timer_channel_zero_oe, timer_channel_zero_out,
         async_receive_en, async_transmit_en, async_transmit_out, spi_enable,
         comparator_enable, ext_irq_enable, ext_irq_rising, debug_mode_select_oe,
         debug_mode_select_out} <= '0;
        {keypad_one_enable, keypad_one_rising, keypad_two_enable, spi_pins_oe,
         spi_pins_out} <= '0;
        ext_en <= '0;
        ext_val <= '0;
    endtask

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
    endtask

    task automatic check_reset();
        for (int p = 0; p < 5; p++) begin
            rd(5'(4 * p + 1));
            chk("dir", 8'h00, rd_v);
            chk("oe", p == 3 ? 8'h7f : 8'hff, oe_all[p]);
            chk("pull_up", p == 3 ? 8'h03 : 8'h00, pu_all[p]);
            chk("pull_dn", 8'h00, pd_all[p]);
        end
        rd(SPM_OPTION_OFS);
        chk("option", 8'h03, rd_v);
        $display("test reset done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #100us;
        num_errors++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        periph_off();
        do_reset();
        check_reset();
        foreach (rows[i]) begin
            wr({rows[i].p, 2'h0}, rows[i].dat);
            wr({rows[i].p, 2'h1}, rows[i].dir);
            wr({rows[i].p, 2'h2}, rows[i].pul);
            rd({rows[i].p, 2'h1});
            chk("dir", rows[i].dir, rd_v);
            chk("oe", rows[i].oe, oe_all[rows[i].p]);
            chk("out", rows[i].out, out_all[rows[i].p] & ~oe_all[rows[i].p]);
            chk("pull_up", rows[i].pu, pu_all[rows[i].p]);
        end
        $display("test table done");
        wr(5'h04, 8'h00);
        wr(5'h05, 8'h00);
        {timer_channel_one_en, timer_channel_one_oe, timer_channel_one_out} <= 3'h7;
        {async_transmit_en, async_transmit_out, spi_enable} <= 3'h7;
        spi_pins_oe <= 4'ha;
        spi_pins_out <= 4'h8;
        timer_channel_zero_en <= 1'b1;
        sync();
        chk("oe_b", 8'h7e, oe_all[1]);
        chk("out_b", 8'h81, out_all[1] & ~oe_all[1]);
        chk("oe_c", 8'h5f, oe_all[2]);
        chk("out_c", 8'h80, out_all[2] & ~oe_all[2]);
        chk("oe_d6", 8'h40, oe_all[3] & 8'h40);
        chk("timer_in", 8'h01, {7'h00, timer_channel_one_in});
        rd(5'h04);
        chk("read_b", 8'h81, rd_v & 8'h81);
        wr(5'h05, 8'h80);
        rd(5'h04);
        chk("read_b", 8'h01, rd_v & 8'h81);
        $display("test drive done");
        wr(5'h01, 8'h00);
        ext_en <= {8'h00, 8'h34, 8'h5f, 8'h02, 8'hff};
        ext_val <= {8'h00, 8'h24, 8'h46, 8'h02, 8'ha5};
        {keypad_one_enable, keypad_two_enable} <= 12'hfff;
        {async_receive_en, comparator_enable, ext_irq_enable} <= 3'h7;
        sync();
        chk("keypad_one", 8'ha5, keypad_one_inputs);
        rd(5'h00);
        chk("read_a", 8'ha5, rd_v);
        chk("keypad_two", 8'h06, {4'h0, keypad_two_inputs});
        chk("spi_in", 8'h0c, {4'h0, spi_slave_select, spi_serial_clock,
            spi_master_in_line, spi_master_out_line});
        chk("misc_in", 8'h0d, {4'h0, async_receive_in, comparator_plus_input,
            comparator_minus_input, ext_irq_input});
        chk("oe_d", 8'h34, oe_all[3] & 8'h34);
        $display("test inputs done");
        wr(5'h02, 8'hf0);
        keypad_one_rising <= 4'hf;
        ext_irq_rising <= 1'b1;
        wr(5'h0e, 8'h04);
        chk("pull_dn_a", 8'hf0, pd_all[0]);
        chk("pull_up_a", 8'h00, pu_all[0]);
        chk("pull_dn_d", 8'h04, pd_all[3] & 8'h04);
        keypad_one_rising <= 4'h0;
        ext_irq_rising <= 1'b0;
        @(posedge ref_clk);
        chk("pull_up_a", 8'hf0, pu_all[0]);
        chk("pull_up_d", 8'h04, pu_all[3] & 8'h04);
        $display("test pulls done");
        ext_en[3] <= 8'h36;
        {timer_channel_zero_oe, timer_channel_zero_out} <= 2'h3;
        {debug_mode_select_oe, debug_mode_select_out} <= 2'h3;
        sync();
        chk("reset_req", 8'h01, {7'h00, reset_pin_request});
        chk("oe_d60", 8'h00, oe_all[3] & 8'h41);
        chk("d_in", 8'h03, {6'h00, timer_channel_zero_in, debug_mode_select_pin});
        ext_en[3] <= 8'h34;
        wr(SPM_OPTION_OFS, 8'h00);
        wr(5'h0d, 8'h00);
        chk("oe_d01", 8'h00, oe_all[3] & 8'h03);
        chk("out_d01", 8'h01, out_all[3] & 8'h03);
        chk("pull_d01", 8'h00, pu_all[3] & 8'h03);
        chk("opt_bits", 8'h00, {6'h00, debug_pin_enable, reset_pin_enable});
        wr(SPM_OPTION_OFS, 8'h01);
        chk("oe_d01", 8'h02, oe_all[3] & 8'h03);
        chk("pull_d01", 8'h02, pu_all[3] & 8'h03);
        wr(5'h1f, 8'hff);
        rd(5'h1f);
        chk("unmapped", 8'h00, rd_v);
        $display("test option done");
        periph_off();
        do_reset();
        check_reset();
        complete_run();
    end
endmodule
